// ---- common/ftl_pkg.sv ----
package ftl_pkg;
  localparam int NUM_ENTRIES = 8;
  localparam int IDX_W = 3;
  localparam int VA_W = 32;
  localparam int VPN_LSB = 11;
  localparam int VPN_W = 21;
  localparam int MASK_W = 14;
  localparam int IDENT_W = 8;
  localparam int PFN_W = 20;
  localparam int PPN_W = 22;
  localparam int PA_PFN_LSB = 10;
  localparam int GRAIN_W = 2;
  localparam int CACHE_W = 3;
  localparam int ADDR_W = 12;
  localparam int HALF_W = 5;

  // coprocessor register number and select; byte offset = (num*span+sel)*4
  localparam int SEL_SPAN = 8;
  localparam int PMASK_NUM = 5;
  localparam int PMASK_SEL = 0;
  localparam int GRAIN_NUM = 5;
  localparam int GRAIN_SEL = 1;
  localparam int EHI_NUM = 10;
  localparam int EHI_SEL = 0;
  localparam int CFG3_NUM = 16;
  localparam int CFG3_SEL = 2;
  localparam logic [ADDR_W-1:0] OFF_PAGE_MASK =
    ADDR_W'((PMASK_NUM * SEL_SPAN + PMASK_SEL) * 4);
  localparam logic [ADDR_W-1:0] OFF_GRAIN =
    ADDR_W'((GRAIN_NUM * SEL_SPAN + GRAIN_SEL) * 4);
  localparam logic [ADDR_W-1:0] OFF_ENTRY_HIGH =
    ADDR_W'((EHI_NUM * SEL_SPAN + EHI_SEL) * 4);
  localparam logic [ADDR_W-1:0] OFF_CONFIG_WORD_THREE =
    ADDR_W'((CFG3_NUM * SEL_SPAN + CFG3_SEL) * 4);
  localparam logic [ADDR_W-1:0] OFF_ENTRY_INDEX = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_ENTRY_WRITE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_ENTRY_LOW0 = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_ENTRY_LOW1 = 12'h060;

  // entry low, entry high, page mask and config word bit layout
  localparam int EL_G = 0;
  localparam int EL_V = 1;
  localparam int EL_D = 2;
  localparam int EL_C_LSB = 3;
  localparam int EL_PFN_LSB = 6;
  localparam int EL_EX_INH = 30;
  localparam int EL_RD_INH = 31;
  localparam int EH_IDENT_LSB = 0;
  localparam int PM_MASK_LSB = 11;
  localparam int CFG_EXT_BIT = 1;
  localparam int CFG_SMALL_BIT = 4;

  localparam logic [GRAIN_W-1:0] GRAIN_1K = 2'h0;
  localparam logic [GRAIN_W-1:0] GRAIN_2K = 2'h1;
  localparam logic [GRAIN_W-1:0] GRAIN_4K = 2'h3;
  localparam logic [GRAIN_W-1:0] GRAIN_RST = GRAIN_4K;

  localparam int IRQ_W = 3;
  localparam int IRQ_REFILL = 0;
  localparam int IRQ_INVALID = 1;
  localparam int IRQ_MODIFIED = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // effective mask pattern to half-select bit position
  localparam int HALF_CODES = 9;
  localparam logic [MASK_W-1:0] HALF_MASK [HALF_CODES] = '{14'h0000,
    14'h0001, 14'h0003, 14'h000f, 14'h003f, 14'h00ff, 14'h03ff, 14'h0fff,
    14'h3fff};
  localparam logic [HALF_W-1:0] HALF_POS [HALF_CODES] = '{5'h0a, 5'h0b,
    5'h0c, 5'h0e, 5'h10, 5'h12, 5'h14, 5'h16, 5'h18};
  localparam logic [HALF_W-1:0] HALF_UNDEF = 5'h0c;

  typedef enum logic [1:0] {
    FTL_REF_FETCH,
    FTL_REF_LOAD,
    FTL_REF_STORE
  } ftl_ref_t;
endpackage

// ---- hdl/ftl_lookup.sv ----
// Summary of operation
// - granularity control selects 4K, 2K or 1K virtual pages.
// - config word three shows the extension present flag set.
// - small page flag of config word three always reads zero.
// - extension behaviour wins wherever the older base mechanism differs.
// - registers placed by coprocessor number and select: 5/0, 5/1, 10/0, 16/2.
// - granularity control qualifies entry low, page mask and entry high.
// - entry hits on masked va bits 31..11 and global or equal identifier.
// - effective mask is entry mask ORed with the granularity mask.
// - effective mask pattern gives half-select bit 10 up to 24.
// - half-select bit zero picks even half fields, else odd half.
// - selected half invalid raises translation invalid exception.
// - load to read-inhibited page faults unless pc-relative and executable.
// - fetch from execute-inhibited page raises translation invalid.
// - store to page without dirty flag raises translation modified.
// - frame bits padded with zeros above or below by granularity.
// - miss with exception level flag clear raises refill exception.
// - refill loads entry high with failing va, low bits grain-masked.
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
module ftl_lookup (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic lk_valid,
  input wire logic [31:0] lk_va,
  input wire ftl_pkg::ftl_ref_t lk_type,
  input wire logic lk_pc_rel,
  input wire logic exception_level_flag,
  output logic lk_hit,
  output logic [31:0] lk_pa,
  output logic [2:0] lk_cache,
  output logic translation_invalid_exc,
  output logic translation_modified_exc,
  output logic refill_exc,
  output logic irq
);
  localparam int N = ftl_pkg::NUM_ENTRIES;
  localparam int VW = ftl_pkg::VPN_W;
  localparam int MW = ftl_pkg::MASK_W;

  // entry storage
  logic [VW-1:0] tlb_vpn_r [N];
  logic [MW-1:0] tlb_mask_r [N];
  logic [ftl_pkg::IDENT_W-1:0] tlb_ident_r [N];
  logic tlb_g_r [N];
  logic [31:0] tlb_lo0_r [N];
  logic [31:0] tlb_lo1_r [N];

  // software registers
  logic [MW-1:0] page_size_mask_r;
  logic [ftl_pkg::GRAIN_W-1:0] grain_r;
  logic [VW-1:0] eh_vpn_r;
  logic [ftl_pkg::IDENT_W-1:0] eh_ident_r;
  logic [31:0] entry_low0_r;
  logic [31:0] entry_low1_r;
  logic [ftl_pkg::IDX_W-1:0] entry_index_r;
  logic [ftl_pkg::IRQ_W-1:0] irq_status_r;
  logic [ftl_pkg::IRQ_W-1:0] irq_mask_r;

  // bus slave state
  logic [ftl_pkg::ADDR_W-1:0] addr_r;
  logic addr_ok_r;
  logic wr_pend_r;
  logic rd_wait_r;
  logic [31:0] hrdata_r;

  logic acc;
  logic wr_fire;
  logic [31:0] config_word_three;

  assign acc = hsel && hready && (htrans == ftl_pkg::HTRANS_NONSEQ);
  assign wr_fire = wr_pend_r && addr_ok_r;
  assign hreadyout = !rd_wait_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_comb begin
    config_word_three = 32'h0;
    config_word_three[ftl_pkg::CFG_EXT_BIT] = 1'b1;
    config_word_three[ftl_pkg::CFG_SMALL_BIT] = 1'b0;
  end

  // ---------------- lookup path ----------------
  logic [N-1:0] match;
  logic [ftl_pkg::IDX_W-1:0] hit_idx;
  logic any_match;
  logic [MW-1:0] eff_mask;
  logic [ftl_pkg::HALF_W-1:0] half_bit;
  logic [31:0] sel_lo;
  logic [ftl_pkg::PFN_W-1:0] sel_pfn;
  logic [ftl_pkg::PPN_W-1:0] pa_pfn;
  logic [31:0] off_mask;
  logic sel_v;
  logic sel_d;
  logic sel_rd_inh;
  logic sel_ex_inh;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ent
      logic [VW-1:0] cmp_mask;
      assign cmp_mask = {{(VW - MW){1'b0}}, tlb_mask_r[gi]};
      assign match[gi] =
        ((tlb_vpn_r[gi] & ~cmp_mask) ==
         (lk_va[31:ftl_pkg::VPN_LSB] & ~cmp_mask)) &&
        (tlb_g_r[gi] || (tlb_ident_r[gi] == eh_ident_r));
    end
  endgenerate

  // lowest matching index wins if software built overlapping entries
  always_comb begin
    hit_idx = '0;
    any_match = 1'b0;
    for (int k = N - 1; k >= 0; k--) begin
      if (match[k]) begin
        hit_idx = ftl_pkg::IDX_W'(k);
        any_match = 1'b1;
      end
    end
  end

  always_comb begin
    eff_mask = tlb_mask_r[hit_idx] | {{(MW - 2){1'b0}}, grain_r};
    half_bit = ftl_pkg::HALF_UNDEF;
    for (int k = 0; k < ftl_pkg::HALF_CODES; k++) begin
      if (eff_mask == ftl_pkg::HALF_MASK[k]) begin
        half_bit = ftl_pkg::HALF_POS[k];
      end
    end
  end

  always_comb begin
    sel_lo = lk_va[half_bit] ? tlb_lo1_r[hit_idx] : tlb_lo0_r[hit_idx];
    sel_pfn = sel_lo[ftl_pkg::EL_PFN_LSB +: ftl_pkg::PFN_W];
    sel_v = sel_lo[ftl_pkg::EL_V];
    sel_d = sel_lo[ftl_pkg::EL_D];
    sel_rd_inh = sel_lo[ftl_pkg::EL_RD_INH];
    sel_ex_inh = sel_lo[ftl_pkg::EL_EX_INH];
    unique case (grain_r)
      ftl_pkg::GRAIN_1K: pa_pfn = {2'h0, sel_pfn};
      ftl_pkg::GRAIN_2K: pa_pfn = {1'h0, sel_pfn, 1'h0};
      default: pa_pfn = {sel_pfn, 2'h0};
    endcase
    off_mask = (32'h1 << half_bit) - 32'h1;
  end

  // single-cycle combinational answer
  assign lk_hit = lk_valid && any_match;
  assign lk_pa = ({pa_pfn, {ftl_pkg::PA_PFN_LSB{1'b0}}} & ~off_mask) |
                 (lk_va & off_mask);
  assign lk_cache = sel_lo[ftl_pkg::EL_C_LSB +: ftl_pkg::CACHE_W];
  assign refill_exc = lk_valid && !any_match &&
                      !exception_level_flag;
  assign translation_invalid_exc = lk_hit && (
    !sel_v ||
    (sel_rd_inh && lk_type == ftl_pkg::FTL_REF_LOAD &&
     !(lk_pc_rel && !sel_ex_inh)) ||
    (sel_ex_inh && lk_type == ftl_pkg::FTL_REF_FETCH));
  assign translation_modified_exc = lk_hit && sel_v && !sel_d &&
    lk_type == ftl_pkg::FTL_REF_STORE;

  // ---------------- bus slave ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= '0;
      addr_ok_r <= 1'b0;
      wr_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
    end else begin
      wr_pend_r <= acc && hwrite && (hsize == ftl_pkg::HSIZE_WORD);
      rd_wait_r <= acc && !hwrite;
      if (acc) begin
        addr_r <= haddr[ftl_pkg::ADDR_W-1:0];
        addr_ok_r <= (haddr[31:ftl_pkg::ADDR_W] == '0);
      end
    end
  end

  // read data sampled in the wait cycle, after any prior write landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0;
    end else if (rd_wait_r) begin
      hrdata_r <= 32'h0;
      if (addr_ok_r) begin
        unique case (addr_r)
          ftl_pkg::OFF_PAGE_MASK:
            hrdata_r <= 32'(page_size_mask_r) << ftl_pkg::PM_MASK_LSB;
          ftl_pkg::OFF_GRAIN: hrdata_r <= 32'(grain_r);
          ftl_pkg::OFF_ENTRY_HIGH: hrdata_r <=
            {eh_vpn_r, 3'h0, eh_ident_r};
          ftl_pkg::OFF_CONFIG_WORD_THREE: hrdata_r <= config_word_three;
          ftl_pkg::OFF_ENTRY_LOW0: hrdata_r <= entry_low0_r;
          ftl_pkg::OFF_ENTRY_LOW1: hrdata_r <= entry_low1_r;
          ftl_pkg::OFF_ENTRY_INDEX: hrdata_r <= 32'(entry_index_r);
          ftl_pkg::OFF_IRQ_STATUS: hrdata_r <= 32'(irq_status_r);
          ftl_pkg::OFF_IRQ_MASK: hrdata_r <= 32'(irq_mask_r);
          default: hrdata_r <= 32'h0;
        endcase
      end
    end
  end

  // control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_size_mask_r <= '0;
      grain_r <= ftl_pkg::GRAIN_RST;
      entry_low0_r <= 32'h0;
      entry_low1_r <= 32'h0;
      entry_index_r <= '0;
      irq_mask_r <= '0;
    end else if (wr_fire) begin
      unique case (addr_r)
        ftl_pkg::OFF_PAGE_MASK:
          page_size_mask_r <= hwdata[ftl_pkg::PM_MASK_LSB +: MW];
        ftl_pkg::OFF_GRAIN:
          grain_r <= hwdata[ftl_pkg::GRAIN_W-1:0];
        ftl_pkg::OFF_ENTRY_LOW0: entry_low0_r <= hwdata;
        ftl_pkg::OFF_ENTRY_LOW1: entry_low1_r <= hwdata;
        ftl_pkg::OFF_ENTRY_INDEX:
          entry_index_r <= hwdata[ftl_pkg::IDX_W-1:0];
        ftl_pkg::OFF_IRQ_MASK: irq_mask_r <= hwdata[ftl_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // entry high: software write, refill capture takes priority
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eh_vpn_r <= '0;
      eh_ident_r <= '0;
    end else if (refill_exc) begin
      eh_vpn_r <= {
        lk_va[ftl_pkg::VA_W-1:ftl_pkg::VPN_LSB+ftl_pkg::GRAIN_W],
        lk_va[ftl_pkg::VPN_LSB +: ftl_pkg::GRAIN_W] & ~grain_r};
    end else if (wr_fire && addr_r == ftl_pkg::OFF_ENTRY_HIGH) begin
      eh_vpn_r <= hwdata[31:ftl_pkg::VPN_LSB];
      eh_ident_r <= hwdata[ftl_pkg::EH_IDENT_LSB +: ftl_pkg::IDENT_W];
    end
  end

  // entry write command loads the indexed entry from the staging registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < N; k++) begin
        tlb_vpn_r[k] <= '0;
        tlb_mask_r[k] <= '0;
        tlb_ident_r[k] <= '0;
        tlb_g_r[k] <= 1'b0;
        tlb_lo0_r[k] <= 32'h0;
        tlb_lo1_r[k] <= 32'h0;
      end
    end else if (wr_fire && addr_r == ftl_pkg::OFF_ENTRY_WRITE) begin
      tlb_vpn_r[entry_index_r] <= eh_vpn_r;
      tlb_mask_r[entry_index_r] <= page_size_mask_r;
      tlb_ident_r[entry_index_r] <= eh_ident_r;
      tlb_g_r[entry_index_r] <= entry_low0_r[ftl_pkg::EL_G] &&
                                entry_low1_r[ftl_pkg::EL_G];
      tlb_lo0_r[entry_index_r] <= entry_low0_r;
      tlb_lo1_r[entry_index_r] <= entry_low1_r;
    end
  end

  // sticky events, write one to clear, new event wins over clear
  logic [ftl_pkg::IRQ_W-1:0] irq_evt;
  logic [ftl_pkg::IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_evt = '0;
    irq_evt[ftl_pkg::IRQ_REFILL] = refill_exc;
    irq_evt[ftl_pkg::IRQ_INVALID] = translation_invalid_exc;
    irq_evt[ftl_pkg::IRQ_MODIFIED] = translation_modified_exc;
    irq_clr = '0;
    if (wr_fire && addr_r == ftl_pkg::OFF_IRQ_STATUS) begin
      irq_clr = hwdata[ftl_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_evt;
    end
  end

  assign irq = |(irq_status_r & irq_mask_r);

  // ---------------- checks ----------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_cfg_rd_req;
    hsel && hready && htrans == ftl_pkg::HTRANS_NONSEQ && !hwrite &&
    haddr[31:ftl_pkg::ADDR_W] == '0 &&
    haddr[ftl_pkg::ADDR_W-1:0] == ftl_pkg::OFF_CONFIG_WORD_THREE;
  endsequence
  sequence s_cfg_rd_done;
    !hreadyout ##1 (hreadyout && hrdata[ftl_pkg::CFG_EXT_BIT] &&
                    !hrdata[ftl_pkg::CFG_SMALL_BIT]);
  endsequence

  a_cfg_read_flags: assert property (s_cfg_rd_req |=> s_cfg_rd_done)
    else $error("config word three flags wrong");
  a_miss_refill: assert property (
    (lk_valid && !lk_hit) |-> (refill_exc == !exception_level_flag))
    else $error("refill not tied to miss and level flag");
  a_refill_capture: assert property (
    refill_exc |=> (eh_vpn_r[VW-1:2] == $past(lk_va[31:13])) &&
    (eh_vpn_r[1:0] == ($past(lk_va[12:11]) & ~$past(grain_r))))
    else $error("entry high not loaded from failing address");
  a_fetch_inhibit: assert property (
    (lk_hit && sel_ex_inh && lk_type == ftl_pkg::FTL_REF_FETCH)
      |-> translation_invalid_exc)
    else $error("fetch from inhibited page not faulted");
  a_store_dirty: assert property (
    (lk_hit && sel_v && !sel_d && lk_type == ftl_pkg::FTL_REF_STORE)
      |-> translation_modified_exc && irq_evt[ftl_pkg::IRQ_MODIFIED])
    else $error("store to clean page not faulted");
  a_invalid_half: assert property (
    (lk_hit && !sel_v) |-> translation_invalid_exc ##1
      irq_status_r[ftl_pkg::IRQ_INVALID])
    else $error("invalid half not faulted or not latched");
  a_grain_pad: assert property (
    (lk_hit && grain_r == ftl_pkg::GRAIN_1K) |-> lk_pa[31:30] == 2'h0)
    else $error("frame padding wrong for finest grain");
  a_grain_mask: assert property (
    (lk_hit && grain_r == ftl_pkg::GRAIN_4K) |-> half_bit >= 5'h0c)
    else $error("granularity not merged into effective mask");
  a_hit_ident: assert property (
    lk_hit |-> (tlb_g_r[hit_idx] || tlb_ident_r[hit_idx] == eh_ident_r))
    else $error("hit on foreign identifier");

  sequence s_rd_req;
    hsel && hready && htrans == ftl_pkg::HTRANS_NONSEQ && !hwrite;
  endsequence
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait: assert property (s_rd_req |=> s_rd_wait)
    else $error("read data phase not one wait state");
  a_write_nowait: assert property (
    (hsel && hready && htrans == ftl_pkg::HTRANS_NONSEQ && hwrite)
      |=> hreadyout)
    else $error("write data phase stalled");
  a_load_inhibit: assert property (
    (lk_hit && sel_rd_inh && lk_type == ftl_pkg::FTL_REF_LOAD &&
     !lk_pc_rel) |-> translation_invalid_exc)
    else $error("load from read inhibited page not faulted");
  a_pc_rel_load: assert property (
    (lk_hit && sel_v && !sel_ex_inh && lk_pc_rel &&
     lk_type == ftl_pkg::FTL_REF_LOAD) |-> !translation_invalid_exc)
    else $error("pc relative load refused on executable page");
  a_hit_no_refill: assert property (
    lk_hit |-> !refill_exc)
    else $error("refill raised on a hit");
  a_event_wins: assert property (
    refill_exc |=> irq_status_r[ftl_pkg::IRQ_REFILL])
    else $error("refill event lost against clear");
  a_half_pick: assert property (
    lk_hit |-> lk_cache == (lk_va[half_bit] ?
      tlb_lo1_r[hit_idx][ftl_pkg::EL_C_LSB +: ftl_pkg::CACHE_W] :
      tlb_lo0_r[hit_idx][ftl_pkg::EL_C_LSB +: ftl_pkg::CACHE_W]))
    else $error("wrong half selected");
  a_pa_offset: assert property (
    lk_hit |-> (lk_pa & off_mask) == (lk_va & off_mask))
    else $error("page offset not passed through");
endmodule

// ---- tb/ftl_lookup_bench.sv ----
module ftl_lookup_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] GR = 32'(ftl_pkg::OFF_GRAIN);
  localparam logic [31:0] EH = 32'(ftl_pkg::OFF_ENTRY_HIGH);
  localparam logic [31:0] ST = 32'(ftl_pkg::OFF_IRQ_STATUS);
  localparam logic [1:0] CG [5] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h1};
  localparam logic [13:0] CM [5] = '{14'h0, 14'h0, 14'h0, 14'hf, 14'h3fff};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, lk_valid, lk_pc_rel, lvl, lk_hit, irq;
  logic [31:0] hrdata, lk_va, lk_pa;
  logic [2:0] lk_cache;
  ftl_pkg::ftl_ref_t lk_type;
  logic tinv, tmod, trefill;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  int seed = 19983;
  logic rd_ph = 1'b0;
  logic [32:0] rq[$];
  logic [38:0] lq[$];
  logic [38:0] lm[$];
  logic [20:0] ev, ehv;
  logic [13:0] em;
  logic [7:0] ea, ca;
  logic [31:0] el0, el1;
  logic [1:0] gr;
  logic [2:0] st, msk;

  ftl_lookup ftl_lookup_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .lk_valid(lk_valid), .lk_va(lk_va),
    .lk_type(lk_type), .lk_pc_rel(lk_pc_rel), .exception_level_flag(lvl),
    .lk_hit(lk_hit), .lk_pa(lk_pa), .lk_cache(lk_cache),
    .translation_invalid_exc(tinv), .translation_modified_exc(tmod),
    .refill_exc(trefill), .irq(irq));
  ftl_pipe_model ftl_pipe_model_inst (.hclk(hclk), .lk_valid(lk_valid),
    .lk_va(lk_va), .lk_type(lk_type), .lk_pc_rel(lk_pc_rel),
    .exception_level_flag(lvl));

  initial begin
    forever #25 hclk = ~hclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [38:0] e, s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask

  always @(negedge hclk) begin
    if (rd_ph && hreadyout === 1'b1)
      chk("register read", 39'(rq.pop_front()),
        {5'h0, hresp, irq, hrdata});
    if (lk_valid === 1'b1 && lq.size() > 0)
      chk("lookup", lq.pop_front(), lm.pop_front() & {lk_hit, lk_pa,
        lk_cache, tinv, tmod, trefill});
  end

  task automatic ahb(input logic w, input logic [31:0] a, d, e);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= ftl_pkg::HTRANS_NONSEQ;
    hsize <= ftl_pkg::HSIZE_WORD;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    if (!w)
      rq.push_back({|(st & msk), e});
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    rd_ph <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, d);
    ahb(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [31:0] a, e);
    ahb(1'b0, a, 32'h0, e);
  endtask

  task automatic load_entry();
    wr(32'(ftl_pkg::OFF_ENTRY_INDEX), 32'h3);
    wr(EH, {ev, 3'h0, ea});
    wr(32'(ftl_pkg::OFF_PAGE_MASK), {7'h0, em, 11'h0});
    rd(32'(ftl_pkg::OFF_PAGE_MASK), {7'h0, em, 11'h0});
    wr(32'(ftl_pkg::OFF_ENTRY_LOW0), el0);
    wr(32'(ftl_pkg::OFF_ENTRY_LOW1), el1);
    wr(32'(ftl_pkg::OFF_ENTRY_WRITE), 32'h1);
  endtask

  task automatic look(input logic [31:0] va, input int t, input logic pc,
      input logic x);
    logic hit, inv, md;
    int hb;
    logic [31:0] el, m, pa;
    logic [21:0] pp;
    hit = ((ev ^ va[31:11]) & ~{7'h0, em}) == 21'h0;
    hit = hit && ((el0[0] && el1[0]) || ea == ca);
    hb = 10 + $countones({em[13:2], em[1:0] | gr});
    el = va[hb] ? el1 : el0;
    pp = {el[25:6], 2'h0};
    if (gr == 2'h0)
      pp = {2'h0, el[25:6]};
    if (gr == 2'h1)
      pp = {1'b0, el[25:6], 1'b0};
    m = (32'h1 << hb) - 32'h1;
    pa = ({pp, 10'h0} & ~m) | (va & m);
    inv = !el[1] || (t == 1 && el[31] && !(pc && !el[30]));
    inv = inv || (t == 0 && el[30]);
    md = el[1] && t == 2 && !el[2];
    lq.push_back(hit ? {1'b1, pa, el[5:3], inv, md, 1'b0} : {38'h0, !x});
    lm.push_back(hit ? {39{1'b1}} : {1'b1, 35'h0, 3'h7});
    st = st | (hit ? {md, inv, 1'b0} : {2'h0, !x});
    if (!hit && !x)
      ehv = {va[31:13], va[12:11] & ~gr};
    ftl_pipe_model_inst.req(va, ftl_pkg::ftl_ref_t'(t[1:0]), pc, x);
  endtask

  initial begin
    logic [31:0] va;
    st = 3'h0;
    msk = 3'h0;
    ea = 8'h5a;
    ca = ea;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'(ftl_pkg::OFF_CONFIG_WORD_THREE), 32'h2);
    rd(GR, 32'h3);
    wr(32'(ftl_pkg::OFF_CONFIG_WORD_THREE), 32'hffffffff);
    rd(32'(ftl_pkg::OFF_CONFIG_WORD_THREE), 32'h2);
    wr(32'h000010a0, 32'h01fff800);
    rd(32'h000010a0, 32'h0);
    rd(32'(ftl_pkg::OFF_PAGE_MASK), 32'h0);
    for (int c = 0; c < 5; c++) begin
      gr = CG[c];
      em = CM[c];
      ev = 21'($random(seed));
      el0 = $random(seed);
      el1 = $random(seed);
      wr(GR, {30'h0, gr});
      rd(GR, {30'h0, gr});
      load_entry();
      for (int k = 0; k < 12; k++) begin
        va = {ev, 11'h0} ^ ($random(seed) & {7'h0, em, 11'h7ff});
        look(va, k % 3, 1'($random(seed)), 1'($random(seed)));
      end
      look({~ev[20], ev[19:0], 11'h5}, 1, 1'b0, c[0]);
    end
    rd(EH, {ehv, 3'h0, ea});
    el0[0] = 1'b0;
    load_entry();
    ca = ea + 8'h1;
    wr(EH, {ev, 3'h0, ca});
    look({ev, 11'h0}, 0, 1'b0, 1'b1);
    rd(ST, {29'h0, st});
    msk = 3'h7;
    wr(32'(ftl_pkg::OFF_IRQ_MASK), 32'h7);
    rd(32'(ftl_pkg::OFF_IRQ_MASK), 32'h7);
    wr(ST, {29'h0, st});
    st = 3'h0;
    rd(ST, 32'h0);
    finish_test();
  end
endmodule

// ---- tb/ftl_pipe_model.sv ----
module ftl_pipe_model (
  input wire logic hclk,
  output logic lk_valid,
  output logic [31:0] lk_va,
  output ftl_pkg::ftl_ref_t lk_type,
  output logic lk_pc_rel,
  output logic exception_level_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    lk_valid = 1'b0;
    lk_va = 32'h0;
    lk_type = ftl_pkg::FTL_REF_FETCH;
    lk_pc_rel = 1'b0;
    exception_level_flag = 1'b0;
  end
  // one request cycle, then va and pc-relative flag scrambled so stale use shows
  task automatic req(input logic [31:0] va, input ftl_pkg::ftl_ref_t ty,
      input logic pc, input logic lvl);
    @(posedge hclk);
    lk_valid <= 1'b1;
    lk_va <= va;
    lk_type <= ty;
    lk_pc_rel <= pc;
    exception_level_flag <= lvl;
    @(posedge hclk);
    lk_valid <= 1'b0;
    lk_va <= ~va;
    lk_pc_rel <= ~pc;
  endtask
endmodule
